// *** rtl/sfrp_pkg.sv ***
// Shared constants, opcode table and types for the serial flash command and read port.
package sfrp_pkg;
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned LEN_W = 9;
  localparam int unsigned CNT_W = 10;
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned SCK_PERIOD_NS = 800;
  localparam int unsigned SCK_HALF_CYC = SCK_PERIOD_NS / (2 * CLK_PERIOD_NS);
  localparam int unsigned SPI_MODE0 = 0;
  localparam int unsigned SPI_MODE3 = 3;

  localparam logic [7:0] OP_READ_FAST = 8'h0b;
  localparam logic [7:0] OP_READ_SLOW = 8'h03;
  localparam logic [7:0] OP_ERASE_4K = 8'h20;
  localparam logic [7:0] OP_ERASE_32K_A = 8'h52;
  localparam logic [7:0] OP_ERASE_32K_B = 8'hd8;
  localparam logic [7:0] OP_CHIP_ERASE_A = 8'h60;
  localparam logic [7:0] OP_CHIP_ERASE_B = 8'hc7;
  localparam logic [7:0] OP_CHIP_ERASE_C = 8'h62;
  localparam logic [7:0] OP_PROGRAM = 8'h02;
  localparam logic [7:0] OP_WR_EN = 8'h06;
  localparam logic [7:0] OP_WR_DIS = 8'h04;
  localparam logic [7:0] OP_OTP_WRITE = 8'h9b;
  localparam logic [7:0] OP_OTP_READ = 8'h77;
  localparam logic [7:0] OP_STAT_RD = 8'h05;
  localparam logic [7:0] OP_STAT_WR = 8'h01;
  localparam logic [7:0] OP_ID_READ = 8'h9f;
  localparam logic [7:0] OP_ID_LEGACY = 8'h15;
  localparam logic [7:0] OP_PWR_DOWN = 8'hb9;
  localparam logic [7:0] OP_PWR_RESUME = 8'hab;
  localparam logic [7:0] DUMMY_BYTE = 8'h00;

  localparam logic [1:0] ADDR_BYTES = 2'h3;
  localparam logic [1:0] DUMMY_NONE = 2'h0;
  localparam logic [1:0] DUMMY_ONE = 2'h1;
  localparam logic [1:0] DUMMY_TWO = 2'h2;
  localparam logic [15:0] MASK_4K = 16'hf000;
  localparam logic [15:0] MASK_32K = 16'h8000;
  localparam logic [15:0] MASK_PAGE = 16'hff00;
  localparam logic [15:0] MASK_CHIP = 16'h0000;
  localparam logic [15:0] MASK_FULL = 16'hffff;

  typedef enum logic [3:0] {
    K_NONE = 4'b0000, K_READ = 4'b0001, K_ERASE_4K = 4'b0010, K_ERASE_32K = 4'b0011,
    K_CHIP_ERASE = 4'b0100, K_PROGRAM = 4'b0101, K_OTP_WRITE = 4'b0110,
    K_OTP_READ = 4'b0111, K_ID = 4'b1000, K_ID_LEGACY = 4'b1001, K_PWR_DOWN = 4'b1010,
    K_PWR_RESUME = 4'b1011, K_WR_EN = 4'b1100, K_WR_DIS = 4'b1101,
    K_STAT_RD = 4'b1110, K_STAT_WR = 4'b1111
  } sfrp_kind_t;

  typedef struct packed {
    logic ok;
    sfrp_kind_t kind;
    logic [1:0] addr_bytes;
    logic [1:0] dummy_bytes;
  } sfrp_cmd_t;

  function automatic sfrp_cmd_t sfrp_decode(input logic [7:0] op);
    sfrp_cmd_t c;
    c = '{ok: 1'b1, kind: K_NONE, addr_bytes: 2'h0, dummy_bytes: DUMMY_NONE};
    case (op)
      OP_READ_FAST: c = '{1'b1, K_READ, ADDR_BYTES, DUMMY_ONE};
      OP_READ_SLOW: c = '{1'b1, K_READ, ADDR_BYTES, DUMMY_NONE};
      OP_ERASE_4K: c = '{1'b1, K_ERASE_4K, ADDR_BYTES, DUMMY_NONE};
      OP_ERASE_32K_A, OP_ERASE_32K_B: c = '{1'b1, K_ERASE_32K, ADDR_BYTES, DUMMY_NONE};
      OP_CHIP_ERASE_A, OP_CHIP_ERASE_B, OP_CHIP_ERASE_C: c.kind = K_CHIP_ERASE;
      OP_PROGRAM: c = '{1'b1, K_PROGRAM, ADDR_BYTES, DUMMY_NONE};
      OP_OTP_WRITE: c = '{1'b1, K_OTP_WRITE, ADDR_BYTES, DUMMY_NONE};
      OP_OTP_READ: c = '{1'b1, K_OTP_READ, ADDR_BYTES, DUMMY_TWO};
      OP_ID_READ: c.kind = K_ID;
      OP_ID_LEGACY: c.kind = K_ID_LEGACY;
      OP_PWR_DOWN: c.kind = K_PWR_DOWN;
      OP_PWR_RESUME: c.kind = K_PWR_RESUME;
      OP_WR_EN: c.kind = K_WR_EN;
      OP_WR_DIS: c.kind = K_WR_DIS;
      OP_STAT_RD: c.kind = K_STAT_RD;
      OP_STAT_WR: c.kind = K_STAT_WR;
      default: c.ok = 1'b0;
    endcase
    return c;
  endfunction : sfrp_decode
endpackage : sfrp_pkg

// *** rtl/sfrp_if.sv ***
// Serial link between the flash end and the controller end.
`timescale 1ns/1ps
interface sfrp_if;
  logic cs_n;
  logic sck;
  logic si;
  logic hold_n;
  logic so;
  logic so_oe_n;
  logic so_line;

  // A released output shows the inverse of its last bit, so late sampling shows up.
  assign so_line = so_oe_n ? ~so : so;

  modport dev (input cs_n, input sck, input si, input hold_n, output so, output so_oe_n);
  modport host (output cs_n, output sck, output si, output hold_n, input so_line);
endinterface : sfrp_if

// *** rtl/sfrp_sync.sv ***
// Two-stage synchroniser for levels arriving from outside the clock domain.
`timescale 1ns/1ps
module sfrp_sync #(
  parameter int unsigned W = 1,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk) begin
    if (srst) begin
      meta_q <= RST;
      q <= RST;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule : sfrp_sync

// *** rtl/sfrp_device.sv ***
// Flash end of the link: command framing, opcode decode and the streaming array read.
// Functional notes
// (RULE1) Mode 0 or 3: sample rising, drive falling.
// (RULE2) Host frames: select, opcode, extra bytes, release.
// (RULE3) All bytes shift most significant bit first.
// (RULE4) Unknown opcode: ignore input until reselect.
// (RULE5) Early release before full header does nothing.
// (RULE6) Three address bytes; top byte is discarded.
// (RULE7) Read 0Bh has one dummy, 03h none.
// (RULE8) After header, stream array bytes, address increments.
// (RULE9) Address wraps from top to zero seamlessly.
// (RULE10) Release ends read at once, output floats.
// (RULE11) Report 4K, 32K, page and chip bases.
// (RULE12) 20h erases 4K; 52h, D8h erase 32K.
// (RULE13) 60h, C7h, 62h erase the whole array.
// (RULE14) 02h programs with address and data bytes.
// (RULE15) 9Bh writes security area; 77h reads it.
// (RULE16) 9Fh and 15h read identification, no address.
// (RULE17) B9h powers down; ABh resumes.
// (RULE18) 06h, 04h, 05h, 01h decode without address.
// (RULE19) Capture only on rising edges while selected.
// (RULE20) Hold freezes link, floats output, starts clock-low.
`timescale 1ns/1ps
module sfrp_device
  import sfrp_pkg::*;
#(
  parameter int unsigned AW = sfrp_pkg::ADDR_W
) (
  input wire logic clk,
  input wire logic srst,
  sfrp_if.dev link,
  input wire logic load_en,
  input wire logic [AW-1:0] load_addr,
  input wire logic [7:0] load_data,
  output logic op_valid,
  output sfrp_pkg::sfrp_kind_t op_kind,
  output logic [AW-1:0] op_addr,
  output logic [AW-1:0] op_base,
  output logic rx_valid,
  output logic [7:0] rx_byte,
  output logic end_valid,
  output logic end_ok
);
  import sfrp_pkg::*;

  typedef enum logic [2:0] {
    D_IDLE = 3'b000, D_OPC = 3'b001, D_ADDR = 3'b010, D_DUMMY = 3'b011,
    D_STREAM = 3'b100, D_SINK = 3'b101, D_IGNORE = 3'b110
  } sfrp_dev_state_t;

  logic [7:0] mem_q [0:(2**AW)-1];
  logic cs_n_s, sck_s, si_s, hold_n_s;
  logic sck_p_q;
  sfrp_dev_state_t state_q;
  sfrp_cmd_t cmd_q, dec;
  logic [2:0] bit_q, out_cnt_q;
  logic [1:0] cnt_q;
  logic [6:0] sh_q;
  logic [7:0] byte_val, out_sh_q;
  logic [AW-1:0] addr_q, addr_full, rd_addr_q;
  logic hold_q, drv_q, so_q, hdr_ok_q, cs_act, cs_act_p_q;
  logic rise_ok, fall_ok, byte_done, hdr_last;
  sfrp_kind_t kind_now;

  sfrp_sync #(.W(4), .RST(4'hb)) u_sync (
    .clk(clk),
    .srst(srst),
    .d({link.cs_n, link.sck, link.si, link.hold_n}),
    .q({cs_n_s, sck_s, si_s, hold_n_s})
  );

  assign cs_act = ~cs_n_s;
  // Edges of the link clock count only while selected and not held.
  assign rise_ok = sck_s & ~sck_p_q & cs_act & ~hold_q; // RULE1 RULE19 RULE20
  assign fall_ok = ~sck_s & sck_p_q & cs_act & ~hold_q & (state_q == D_STREAM); // RULE1
  assign byte_done = (bit_q == 3'h7);
  assign byte_val = {sh_q, si_s}; // RULE3
  assign dec = sfrp_decode(byte_val); // RULE12 RULE13 RULE14 RULE15 RULE16 RULE17 RULE18
  assign kind_now = (state_q == D_OPC) ? dec.kind : cmd_q.kind;
  assign addr_full = (state_q == D_ADDR) ? {addr_q[AW-9:0], byte_val} : addr_q; // RULE6

  // The header ends on the last opcode, address or dummy byte that the command needs.
  always_comb begin
    hdr_last = 1'b0;
    if (rise_ok && byte_done) begin
      case (state_q)
        D_OPC: hdr_last = dec.ok && (dec.addr_bytes == 2'h0);
        D_ADDR: hdr_last = (cnt_q == 2'h0) && (cmd_q.dummy_bytes == DUMMY_NONE);
        D_DUMMY: hdr_last = (cnt_q == 2'h0);
        default: hdr_last = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (load_en) begin
      mem_q[load_addr] <= load_data;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      sck_p_q <= 1'b0;
      cs_act_p_q <= 1'b0;
    end else begin
      sck_p_q <= sck_s;
      cs_act_p_q <= cs_act;
    end
  end

  always_ff @(posedge clk) begin
    if (srst || !cs_act) begin
      hold_q <= 1'b0;
    end else if (!hold_n_s && !sck_s) begin
      hold_q <= 1'b1; // RULE20
    end else if (hold_n_s) begin
      hold_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst || !cs_act) begin
      state_q <= D_IDLE; // RULE5 RULE10
      cnt_q <= 2'h0;
    end else if (state_q == D_IDLE) begin
      state_q <= D_OPC; // RULE2
    end else if (rise_ok && byte_done) begin
      case (state_q)
        D_OPC: begin
          cmd_q <= dec;
          cnt_q <= dec.addr_bytes - 2'h1;
          if (!dec.ok) begin
            state_q <= D_IGNORE; // RULE4
          end else if (dec.addr_bytes != 2'h0) begin
            state_q <= D_ADDR;
          end else begin
            state_q <= D_SINK;
          end
        end
        D_ADDR: begin
          cnt_q <= (cnt_q == 2'h0) ? cmd_q.dummy_bytes - 2'h1 : cnt_q - 2'h1;
          if (cnt_q == 2'h0 && cmd_q.dummy_bytes != DUMMY_NONE) begin
            state_q <= D_DUMMY; // RULE7
          end else if (cnt_q == 2'h0) begin
            state_q <= (cmd_q.kind == K_READ) ? D_STREAM : D_SINK; // RULE8
          end
        end
        D_DUMMY: begin
          cnt_q <= cnt_q - 2'h1;
          if (cnt_q == 2'h0) begin
            state_q <= (cmd_q.kind == K_READ) ? D_STREAM : D_SINK; // RULE7 RULE8
          end
        end
        default: state_q <= state_q;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst || state_q == D_IDLE) begin
      bit_q <= 3'h0;
      sh_q <= 7'h00;
      addr_q <= '0;
    end else if (rise_ok && state_q != D_IGNORE) begin
      bit_q <= bit_q + 3'h1;
      sh_q <= byte_val[6:0];
      if (byte_done && state_q == D_ADDR) begin
        addr_q <= addr_full; // RULE6
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst || state_q == D_IDLE) begin
      hdr_ok_q <= 1'b0;
    end else if (hdr_last) begin
      hdr_ok_q <= 1'b1;
    end
  end

  // Array data leaves on falling edges; the counter wraps at the top of the array.
  always_ff @(posedge clk) begin
    if (srst || !cs_act) begin
      drv_q <= 1'b0;
      so_q <= 1'b0;
      out_cnt_q <= 3'h0;
      out_sh_q <= 8'h00;
      rd_addr_q <= '0;
    end else if (hdr_last) begin
      rd_addr_q <= addr_full;
      out_cnt_q <= 3'h0;
    end else if (fall_ok) begin
      drv_q <= 1'b1;
      out_cnt_q <= out_cnt_q + 3'h1;
      if (out_cnt_q == 3'h0) begin
        so_q <= mem_q[rd_addr_q][7]; // RULE3 RULE8
        out_sh_q <= {mem_q[rd_addr_q][6:0], 1'b0};
        rd_addr_q <= rd_addr_q + 1'b1; // RULE9
      end else begin
        so_q <= out_sh_q[7];
        out_sh_q <= {out_sh_q[6:0], 1'b0};
      end
    end
  end

  assign link.so = so_q;
  assign link.so_oe_n = ~drv_q | hold_q | ~cs_act; // RULE10 RULE20

  always_ff @(posedge clk) begin
    if (srst) begin
      op_valid <= 1'b0;
      op_kind <= K_NONE;
      op_addr <= '0;
      op_base <= '0;
    end else begin
      op_valid <= hdr_last; // RULE5
      if (hdr_last) begin
        op_kind <= kind_now;
        op_addr <= addr_full;
        case (kind_now)
          K_ERASE_4K: op_base <= addr_full & MASK_4K[AW-1:0]; // RULE11
          K_ERASE_32K: op_base <= addr_full & MASK_32K[AW-1:0]; // RULE11
          K_PROGRAM: op_base <= addr_full & MASK_PAGE[AW-1:0]; // RULE11
          K_CHIP_ERASE: op_base <= MASK_CHIP[AW-1:0]; // RULE11
          default: op_base <= addr_full & MASK_FULL[AW-1:0];
        endcase
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rx_valid <= 1'b0;
      rx_byte <= 8'h00;
    end else begin
      rx_valid <= rise_ok && byte_done && (state_q == D_SINK);
      if (rise_ok && byte_done && state_q == D_SINK) begin
        rx_byte <= byte_val;
      end
    end
  end

  // A frame ends on release; it counts only with a full header on a byte boundary.
  always_ff @(posedge clk) begin
    if (srst) begin
      end_valid <= 1'b0;
      end_ok <= 1'b0;
    end else begin
      end_valid <= cs_act_p_q && !cs_act && (state_q != D_IDLE);
      end_ok <= hdr_ok_q && (bit_q == 3'h0) && (state_q != D_IGNORE); // RULE5
    end
  end
endmodule : sfrp_device

// *** rtl/sfrp_host.sv ***
// Controller end of the link: frames commands, makes the link clock and collects read data.
`timescale 1ns/1ps
module sfrp_host
  import sfrp_pkg::*;
#(
  parameter int unsigned HALF = sfrp_pkg::SCK_HALF_CYC,
  parameter int unsigned MODE = sfrp_pkg::SPI_MODE0
) (
  input wire logic clk,
  input wire logic srst,
  sfrp_if.host link,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic [7:0] req_opcode,
  input wire logic [23:0] req_addr,
  input wire logic [1:0] req_addr_bytes,
  input wire logic [1:0] req_dummy_bytes,
  input wire logic [sfrp_pkg::LEN_W-1:0] req_len,
  input wire logic [7:0] wr_data,
  output logic wr_take,
  output logic rd_valid,
  output logic [7:0] rd_byte,
  input wire logic hold_req
);
  import sfrp_pkg::*;

  typedef enum logic [2:0] {
    H_IDLE = 3'b000, H_SETUP = 3'b001, H_LOW = 3'b010, H_HIGH = 3'b011,
    H_END = 3'b100, H_GAP = 3'b101
  } sfrp_host_state_t;

  localparam logic IDLE_SCK = (MODE == SPI_MODE3);

  sfrp_host_state_t state_q;
  logic [15:0] half_q;
  logic [2:0] bit_q;
  logic [CNT_W-1:0] byte_q, total_q, nxt_idx;
  logic [3:0] hdr_q;
  logic [1:0] ab_q;
  logic [23:0] addr_q;
  logic [7:0] tx_q, rx_q, nxt_byte;
  logic so_s, tick, hold_q;

  sfrp_sync #(.W(1), .RST(1'b0)) u_sync (
    .clk(clk),
    .srst(srst),
    .d(link.so_line),
    .q(so_s)
  );

  assign tick = (half_q == 16'(HALF - 1)) && !hold_q;
  assign req_ready = (state_q == H_IDLE);
  assign nxt_idx = byte_q + 1'b1;
  assign link.hold_n = ~hold_q;
  assign rd_byte = rx_q;

  // Opcode, then address bytes high first, then dummy bytes, then user data.
  always_comb begin
    nxt_byte = wr_data;
    if (nxt_idx <= CNT_W'(ab_q)) begin
      nxt_byte = 8'(addr_q >> (5'd8 * 5'(ab_q - nxt_idx[1:0])));
    end else if (nxt_idx < CNT_W'(hdr_q)) begin
      nxt_byte = DUMMY_BYTE;
    end
  end

  always_ff @(posedge clk) begin
    if (srst || state_q == H_IDLE || tick) begin
      half_q <= 16'h0000;
    end else if (!hold_q) begin
      half_q <= half_q + 16'h0001;
    end
  end

  always_ff @(posedge clk) begin
    if (srst || !hold_req) begin
      hold_q <= 1'b0;
    end else if (state_q == H_LOW && half_q == 16'h0000) begin
      // Hold starts at the head of a low phase, so both ends resync before the next edge.
      hold_q <= 1'b1; // RULE20
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_q <= H_IDLE;
      link.cs_n <= 1'b1;
      link.sck <= IDLE_SCK;
      link.si <= 1'b0;
      bit_q <= 3'h0;
      byte_q <= '0;
      total_q <= '0;
      hdr_q <= 4'h0;
      ab_q <= 2'h0;
      addr_q <= 24'h000000;
      tx_q <= 8'h00;
      rx_q <= 8'h00;
      rd_valid <= 1'b0;
      wr_take <= 1'b0;
    end else begin
      rd_valid <= 1'b0;
      wr_take <= 1'b0;
      case (state_q)
        H_IDLE: begin
          link.sck <= IDLE_SCK;
          if (req_valid) begin
            state_q <= H_SETUP;
            link.cs_n <= 1'b0;
            ab_q <= req_addr_bytes;
            addr_q <= req_addr;
            hdr_q <= 4'h1 + 4'(req_addr_bytes) + 4'(req_dummy_bytes);
            total_q <= CNT_W'(4'h1 + 4'(req_addr_bytes) + 4'(req_dummy_bytes)) + CNT_W'(req_len);
            byte_q <= '0;
            bit_q <= 3'h0;
            tx_q <= req_opcode;
          end
        end
        H_SETUP: if (tick) begin
          state_q <= H_LOW;
          link.sck <= 1'b0;
          link.si <= tx_q[7];
        end
        H_LOW: if (tick) begin
          state_q <= H_HIGH;
          link.sck <= 1'b1;
        end
        H_HIGH: if (tick) begin
          rx_q <= {rx_q[6:0], so_s};
          bit_q <= bit_q + 3'h1;
          if (bit_q != 3'h7) begin
            state_q <= H_LOW;
            link.sck <= 1'b0;
            tx_q <= {tx_q[6:0], 1'b0};
            link.si <= tx_q[6];
          end else begin
            rd_valid <= (byte_q >= CNT_W'(hdr_q));
            byte_q <= nxt_idx;
            if (nxt_idx == total_q) begin
              state_q <= H_END;
              link.sck <= IDLE_SCK;
            end else begin
              state_q <= H_LOW;
              link.sck <= 1'b0;
              tx_q <= nxt_byte;
              link.si <= nxt_byte[7];
              wr_take <= (nxt_idx >= CNT_W'(hdr_q));
            end
          end
        end
        H_END: if (tick) begin
          state_q <= H_GAP;
          link.cs_n <= 1'b1;
        end
        H_GAP: if (tick) begin
          state_q <= H_IDLE;
        end
        default: state_q <= H_IDLE;
      endcase
    end
  end
endmodule : sfrp_host

// *** verif/sfrp_props.sv ***
// Timing and drive checks on the serial link between the two ends.
`timescale 1ns/1ps
module sfrp_props (
  input wire logic clk,
  input wire logic srst,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic si,
  input wire logic hold_n,
  input wire logic so,
  input wire logic so_oe_n
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  property p_desel_float;
    cs_n [*5] |-> so_oe_n;
  endproperty
  a_desel_float: assert property (p_desel_float)
    else $error("serial output driven while deselected");

  property p_hold_float;
    !hold_n [*5] |-> so_oe_n;
  endproperty
  a_hold_float: assert property (p_hold_float)
    else $error("serial output driven during hold");

  property p_so_after_fall;
    $changed(so) && !so_oe_n && !$past(so_oe_n) |->
      !$past(sck, 2) || !$past(sck, 3) || !$past(sck, 4);
  endproperty
  a_so_after_fall: assert property (p_so_after_fall)
    else $error("serial output changed away from a falling clock");

  property p_drive_needs_sel;
    !so_oe_n |-> !$past(cs_n, 4);
  endproperty
  a_drive_needs_sel: assert property (p_drive_needs_sel)
    else $error("serial output driven without selection");

  property p_drive_after_header;
    $fell(so_oe_n) |-> !cs_n && !$past(cs_n, 200);
  endproperty
  a_drive_after_header: assert property (p_drive_after_header)
    else $error("serial output driven before a full header");

  property p_hold_start;
    $fell(hold_n) |-> !sck && !cs_n;
  endproperty
  a_hold_start: assert property (p_hold_start)
    else $error("hold started with clock high or deselected");

  property p_si_stable;
    !cs_n && sck && $past(sck) |-> $stable(si);
  endproperty
  a_si_stable: assert property (p_si_stable)
    else $error("serial input moved while clock high");

  property p_cs_idle_clock;
    $changed(cs_n) |-> !sck;
  endproperty
  a_cs_idle_clock: assert property (p_cs_idle_clock)
    else $error("chip select moved with clock high");

  property p_sck_high_len;
    $rose(sck) |-> sck [*4];
  endproperty
  a_sck_high_len: assert property (p_sck_high_len)
    else $error("link clock high phase too short");
endmodule : sfrp_props

// *** verif/test_serial_flash_cmd_read_port.sv ***
// Self-checking bench joining the controller and flash ends over the serial link.
`timescale 1ns/1ps
module test_serial_flash_cmd_read_port;
  import sfrp_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic load_en = 1'b0;
  logic [15:0] load_addr = 16'h0000;
  logic [7:0] load_data = 8'h00;
  logic req_valid = 1'b0;
  logic [7:0] req_opcode = 8'h00;
  logic [23:0] req_addr = 24'h000000;
  logic [1:0] req_addr_bytes = 2'h0;
  logic [1:0] req_dummy_bytes = 2'h0;
  logic [8:0] req_len = 9'h000;
  logic hold_req = 1'b0;
  logic req_ready, wr_take, rd_valid, op_valid, rx_valid, end_valid, end_ok, endok_s;
  logic [7:0] rd_byte, rx_byte, wr_data;
  logic [15:0] op_addr, op_base, addr_s, base_s;
  sfrp_kind_t op_kind, kind_s;
  logic [7:0] mem [0:65535];
  logic [7:0] wq [0:255];
  logic [7:0] rdq[$];
  logic [7:0] rxq[$];
  logic end_seen = 1'b0;
  int wi = 0;
  int ops = 0;
  int fails = 0;
  int comparisons = 0;
  logic [7:0] op_t [17] = '{OP_ERASE_4K, OP_ERASE_32K_A, OP_ERASE_32K_B, OP_CHIP_ERASE_A,
    OP_CHIP_ERASE_B, OP_CHIP_ERASE_C, OP_PROGRAM, OP_OTP_WRITE, OP_OTP_READ, OP_ID_READ,
    OP_ID_LEGACY, OP_PWR_DOWN, OP_PWR_RESUME, OP_WR_EN, OP_WR_DIS, OP_STAT_RD, OP_STAT_WR};
  sfrp_kind_t kd_t [17] = '{K_ERASE_4K, K_ERASE_32K, K_ERASE_32K, K_CHIP_ERASE, K_CHIP_ERASE,
    K_CHIP_ERASE, K_PROGRAM, K_OTP_WRITE, K_OTP_READ, K_ID, K_ID_LEGACY, K_PWR_DOWN,
    K_PWR_RESUME, K_WR_EN, K_WR_DIS, K_STAT_RD, K_STAT_WR};
  int len_t [17] = '{0, 0, 0, 0, 0, 0, 256, 2, 1, 4, 2, 0, 0, 0, 0, 2, 1};

  sfrp_if link ();
  sfrp_device i_sfrp_device (.clk(clk), .srst(srst), .link(link.dev), .load_en(load_en),
    .load_addr(load_addr), .load_data(load_data), .op_valid(op_valid), .op_kind(op_kind),
    .op_addr(op_addr), .op_base(op_base), .rx_valid(rx_valid), .rx_byte(rx_byte),
    .end_valid(end_valid), .end_ok(end_ok));
  sfrp_host i_sfrp_host (.clk(clk), .srst(srst), .link(link.host), .req_valid(req_valid),
    .req_ready(req_ready), .req_opcode(req_opcode), .req_addr(req_addr),
    .req_addr_bytes(req_addr_bytes), .req_dummy_bytes(req_dummy_bytes), .req_len(req_len),
    .wr_data(wr_data), .wr_take(wr_take), .rd_valid(rd_valid), .rd_byte(rd_byte),
    .hold_req(hold_req));
  sfrp_props i_sfrp_props (.clk(clk), .srst(srst), .cs_n(link.cs_n), .sck(link.sck),
    .si(link.si), .hold_n(link.hold_n), .so(link.so), .so_oe_n(link.so_oe_n));

  assign wr_data = wq[wi[7:0]];

  initial begin
    forever #50 clk = ~clk;
  end

  always @(negedge clk) begin
    if (wr_take) wi <= wi + 1;
  end

  always @(posedge clk) begin
    if (rd_valid) rdq.push_back(rd_byte);
    if (rx_valid) rxq.push_back(rx_byte);
    if (op_valid) begin
      ops++;
      kind_s = op_kind;
      addr_s = op_addr;
      base_s = op_base;
    end
    if (end_valid) begin
      end_seen = 1'b1;
      endok_s = end_ok;
    end
  end

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic wrap_up();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : wrap_up

  task automatic fill(input logic [15:0] s);
    for (int i = 0; i < 16; i++) begin
      @(negedge clk);
      load_en = 1'b1;
      load_addr = s + 16'(i);
      load_data = 8'($urandom);
      mem[load_addr] = load_data;
    end
    @(negedge clk);
    load_en = 1'b0;
  endtask : fill

  task automatic xfer(input logic [7:0] op, input logic [23:0] a, input logic [1:0] ab,
                      input logic [1:0] db, input int len, input sfrp_kind_t k, input logic good);
    int n;
    logic [15:0] base;
    for (int i = 0; i < 256; i++) wq[i] = 8'($urandom);
    rdq.delete();
    rxq.delete();
    ops = 0;
    end_seen = 1'b0;
    endok_s = 1'bx;
    @(negedge clk);
    wi = 0;
    req_opcode = op;
    req_addr = a;
    req_addr_bytes = ab;
    req_dummy_bytes = db;
    req_len = 9'(len);
    req_valid = 1'b1;
    do @(posedge clk); while (req_ready !== 1'b1);
    @(negedge clk);
    req_valid = 1'b0;
    n = 0;
    while (!end_seen && n < 30000) begin
      @(posedge clk);
      n++;
    end
    @(negedge clk);
    base = (k == K_ERASE_4K) ? (a[15:0] & MASK_4K) : (k == K_ERASE_32K) ? (a[15:0] & MASK_32K)
      : (k == K_PROGRAM) ? (a[15:0] & MASK_PAGE) : (k == K_CHIP_ERASE) ? 16'h0000 : a[15:0];
    check("frame end", 16'h0001, {15'h0000, end_seen});
    check("op count", good ? 16'h0001 : 16'h0000, 16'(ops));
    check("end ok", {15'h0000, good}, {15'h0000, endok_s});
    if (good) check("op kind", {12'h000, k}, {12'h000, kind_s});
    if (good && (ab == 2'h3 || k == K_CHIP_ERASE)) check("op base", base, base_s);
    if (good && ab == 2'h3) check("op addr", a[15:0], addr_s);
    if (k == K_READ) begin
      check("read count", 16'(len), 16'(rdq.size()));
      for (int i = 0; i < len; i++) begin
        check("read byte", {8'h00, mem[16'(a[15:0] + i)]}, {8'h00, rdq[i]});
      end
    end else begin
      check("rx count", good ? 16'(len) : 16'h0000, 16'(rxq.size()));
      if (good) begin
        for (int i = 0; i < len; i++) check("rx byte", {8'h00, wq[i]}, {8'h00, rxq[i]});
      end
    end
  endtask : xfer

  initial begin
    repeat (60000) @(posedge clk);
    fails++;
    wrap_up();
  end

  initial begin
    logic [23:0] ra;
    void'($urandom(50));
    repeat (20) @(posedge clk);
    @(negedge clk);
    srst = 1'b0;
    ra = 24'($urandom);
    ra[3:0] = 4'h0;
    fill(16'hfff0);
    fill(16'h0000);
    fill(ra[15:0]);
    xfer(OP_READ_SLOW, ra, 2'h3, 2'h0, 8, K_READ, 1'b1);
    xfer(OP_READ_FAST, {8'ha5, 16'hfffd}, 2'h3, 2'h1, 6, K_READ, 1'b1);
    fork
      begin
        repeat (300) @(negedge clk);
        hold_req = 1'b1;
        repeat (60) @(negedge clk);
        hold_req = 1'b0;
      end
    join_none
    xfer(OP_READ_SLOW, 24'h000004, 2'h3, 2'h0, 8, K_READ, 1'b1);
    for (int i = 0; i < 17; i++) begin
      xfer(op_t[i], 24'($urandom), (i < 3 || (i > 5 && i < 9)) ? 2'h3 : 2'h0,
           (i == 8) ? 2'h2 : 2'h0, len_t[i], kd_t[i], 1'b1);
    end
    xfer(8'h5a, ra, 2'h3, 2'h0, 2, K_NONE, 1'b0);
    xfer(OP_READ_SLOW, ra, 2'h0, 2'h0, 0, K_READ, 1'b0);
    xfer(OP_READ_FAST, ra, 2'h3, 2'h1, 4, K_READ, 1'b1);
    wrap_up();
  end
endmodule : test_serial_flash_cmd_read_port
